//--- core/accel_out_pkg.sv
package accel_out_pkg;

  // Register map of the output data group
  localparam logic [7:0] ADDR_TEMP = 8'h01;
  localparam logic [7:0] ADDR_MAG_LOW = 8'h02;
  localparam logic [7:0] ADDR_MAG_HIGH = 8'h03;
  localparam logic [7:0] ADDR_X_LOW = 8'h04;
  localparam logic [7:0] ADDR_X_HIGH = 8'h05;
  localparam logic [7:0] ADDR_Y_LOW = 8'h06;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h07;
  localparam logic [7:0] ADDR_Z_LOW = 8'h08;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h09;

  // Reset values
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [11:0] MAG_RESET = 12'h000;
  localparam logic [11:0] AXIS_RESET = 12'h000;
  localparam logic POLARITY_RESET = 1'b1;
  localparam logic DRIVER_RESET = 1'b0;
  localparam logic ROUTE_RESET = 1'b0;

  // Conversion channels in acquisition order
  localparam logic [1:0] CHAN_TEMP = 2'h0;
  localparam logic [1:0] CHAN_Z = 2'h3;
  localparam int ROOT_STEPS = 12;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_GAP_NS = 40000;
  localparam int CONV_GAP_CYCLES = CONV_GAP_NS / CLK_PERIOD_NS;
  localparam int BOOT_SHORT_NS = 10000;
  localparam int BOOT_SHORT_CYCLES = (BOOT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_LONG_NS = 1000000;
  localparam int BOOT_LONG_CYCLES = (BOOT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_ROOT, CONV_LATCH} conv_state_type;
  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_state_type;

endpackage

//--- core/accel_output_data_registers.sv
`timescale 1ns/10ps
module accel_output_data_registers #(
  parameter int BOOT_LONG_CYCLES = accel_out_pkg::BOOT_LONG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic boot_strap_select,
  input wire logic boot_finish,
  input wire logic soft_reset,
  input wire logic hibernate_exit,
  input wire logic boot_irq_enable,
  input wire logic setup_write,
  input wire logic setup_polarity,
  input wire logic setup_driver,
  input wire logic setup_route,
  input wire logic byte_order_select,
  input wire logic fast_read_select,
  input wire logic magnitude_enable,
  input wire logic odr_tick,
  output logic adc_start,
  output logic [1:0] adc_channel,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_first,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  output logic reg_refused,
  output logic boot_done_flag,
  output logic sample_ready_flag,
  output logic irq_polarity,
  output logic irq_driver_type,
  output logic boot_route_second,
  output logic first_irq_pin_o,
  output logic first_irq_pin_oe,
  output logic second_irq_pin_o,
  output logic second_irq_pin_oe
);

  // One axis byte as seen at its low or high address
  function automatic logic [7:0] axis_byte(input logic [11:0] v, input logic high,
                                           input logic big, input logic fast);
    if (!high && (big || fast))
    begin
      axis_byte = v[11:4];
    end
    else if (!high)
    begin
      axis_byte = v[7:0];
    end
    else if (big)
    begin
      axis_byte = {v[3:0], 4'h0};
    end
    else
    begin
      axis_byte = {{4{v[11]}}, v[11:8]};
    end
  endfunction

  // Level and enable of an interrupt pin
  function automatic logic [1:0] pin_drive(input logic active, input logic pol,
                                           input logic od);
    logic lvl;
    lvl = active ? pol : ~pol;
    if (od)
    begin
      pin_drive = {1'b0, ~lvl};
    end
    else
    begin
      pin_drive = {lvl, 1'b1};
    end
  endfunction

  logic strap_s1_q;
  logic strap_s2_q;
  logic boot_done_q;
  logic ready_q;
  logic pol_q;
  logic drv_q;
  logic route_q;
  accel_out_pkg::conv_state_type conv_q;
  logic [1:0] chan_q;
  logic [8:0] gap_q;
  logic got_q;
  logic [7:0] temp_buf_q;
  logic [11:0] x_buf_q;
  logic [11:0] y_buf_q;
  logic [11:0] z_buf_q;
  logic signed [23:0] x_wide;
  logic signed [23:0] y_wide;
  logic signed [23:0] z_wide;
  logic [11:0] root_q;
  logic [3:0] step_q;
  logic [7:0] temp_q;
  logic [11:0] mag_q;
  logic [11:0] x_q;
  logic [11:0] y_q;
  logic [11:0] z_q;
  logic [7:0] ptr_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic refused_q;
  accel_out_pkg::pulse_state_type pulse_q;
  logic [13:0] pulse_cnt_q;
  logic pulse_second_q;
  logic pulse_pol_q;
  logic pulse_od_q;
  logic [1:0] pin1_q;
  logic [1:0] pin2_q;
  logic start_q;

  logic access;
  logic [7:0] addr_use;
  logic [7:0] addr_next;
  logic [7:0] read_byte;
  logic clears_ready;
  logic latch_now;
  logic [23:0] sum_sq;
  logic [11:0] trial;
  logic [23:0] trial_sq;
  logic [1:0] drive1;
  logic [1:0] drive2;

  assign access = reg_rd || reg_wr;
  assign addr_use = reg_first ? reg_addr : ptr_q;
  assign latch_now = (conv_q == accel_out_pkg::CONV_LATCH);

  // Strap pin is asynchronous to the core clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end
    else
    begin
      strap_s1_q <= boot_strap_select;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Boot done: set wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      boot_done_q <= 1'b0;
    end
    else if (boot_finish)
    begin
      boot_done_q <= 1'b1;
    end
    else if (soft_reset || hibernate_exit)
    begin
      boot_done_q <= 1'b0;
    end
  end

  // Pin setup survives soft reset; writes only land after boot
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pol_q <= accel_out_pkg::POLARITY_RESET;
      drv_q <= accel_out_pkg::DRIVER_RESET;
      route_q <= accel_out_pkg::ROUTE_RESET;
    end
    else if (hibernate_exit)
    begin
      pol_q <= accel_out_pkg::POLARITY_RESET;
      drv_q <= accel_out_pkg::DRIVER_RESET;
      route_q <= accel_out_pkg::ROUTE_RESET;
    end
    else if (setup_write && boot_done_q)
    begin
      pol_q <= setup_polarity;
      drv_q <= setup_driver;
      route_q <= setup_route;
    end
  end

  // Sum of squares of the buffered axes, widened first so no product is cut
  always_comb
  begin
    x_wide = 24'($signed(x_buf_q));
    y_wide = 24'($signed(y_buf_q));
    z_wide = 24'($signed(z_buf_q));
    sum_sq = 24'(x_wide * x_wide) + 24'(y_wide * y_wide) + 24'(z_wide * z_wide);
    trial = root_q | (12'h800 >> step_q);
    trial_sq = 24'(trial) * 24'(trial);
  end

  // Acquisition sequencer, temperature then X, Y, Z
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      conv_q <= accel_out_pkg::CONV_IDLE;
      chan_q <= accel_out_pkg::CHAN_TEMP;
      gap_q <= 9'h000;
      got_q <= 1'b0;
      start_q <= 1'b0;
      step_q <= 4'h0;
      root_q <= 12'h000;
    end
    else
    begin
      start_q <= 1'b0;
      unique case (conv_q)
        accel_out_pkg::CONV_IDLE:
        begin
          if (odr_tick && boot_done_q)
          begin
            conv_q <= accel_out_pkg::CONV_RUN;
            chan_q <= accel_out_pkg::CHAN_TEMP;
            gap_q <= 9'h000;
            got_q <= 1'b0;
            start_q <= 1'b1;
          end
        end
        accel_out_pkg::CONV_RUN:
        begin
          if (32'(gap_q) < accel_out_pkg::CONV_GAP_CYCLES - 1)
          begin
            gap_q <= gap_q + 9'h001;
          end
          if (adc_done)
          begin
            got_q <= 1'b1;
          end
          if ((got_q || adc_done) && 32'(gap_q) >= accel_out_pkg::CONV_GAP_CYCLES - 1)
          begin
            got_q <= 1'b0;
            gap_q <= 9'h000;
            if (chan_q == accel_out_pkg::CHAN_Z)
            begin
              step_q <= 4'h0;
              root_q <= 12'h000;
              conv_q <= magnitude_enable ? accel_out_pkg::CONV_ROOT
                                         : accel_out_pkg::CONV_LATCH;
            end
            else
            begin
              chan_q <= chan_q + 2'h1;
              start_q <= 1'b1;
            end
          end
        end
        accel_out_pkg::CONV_ROOT:
        begin
          // Buffers hold still during the search; Z may land on the last run edge
          if (trial_sq <= sum_sq)
          begin
            root_q <= trial;
          end
          step_q <= step_q + 4'h1;
          if (32'(step_q) == accel_out_pkg::ROOT_STEPS - 1)
          begin
            conv_q <= accel_out_pkg::CONV_LATCH;
          end
        end
        accel_out_pkg::CONV_LATCH:
        begin
          conv_q <= accel_out_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // Channel buffers fill as each conversion ends
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      temp_buf_q <= accel_out_pkg::TEMP_RESET;
      x_buf_q <= accel_out_pkg::AXIS_RESET;
      y_buf_q <= accel_out_pkg::AXIS_RESET;
      z_buf_q <= accel_out_pkg::AXIS_RESET;
    end
    else if (conv_q == accel_out_pkg::CONV_RUN && adc_done)
    begin
      unique case (chan_q)
        2'h0: temp_buf_q <= adc_result[7:0];
        2'h1: x_buf_q <= adc_result;
        2'h2: y_buf_q <= adc_result;
        2'h3: z_buf_q <= adc_result;
      endcase
    end
  end

  // Output registers load in one cycle; mag_q loads only when magnitude_enable is set
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      temp_q <= accel_out_pkg::TEMP_RESET;
      mag_q <= accel_out_pkg::MAG_RESET;
      x_q <= accel_out_pkg::AXIS_RESET;
      y_q <= accel_out_pkg::AXIS_RESET;
      z_q <= accel_out_pkg::AXIS_RESET;
    end
    else if (latch_now)
    begin
      temp_q <= temp_buf_q;
      x_q <= x_buf_q;
      y_q <= y_buf_q;
      z_q <= z_buf_q;
      if (magnitude_enable)
      begin
        mag_q <= root_q;
      end
    end
  end

  // Read data decode
  always_comb
  begin
    read_byte = 8'h00;
    clears_ready = 1'b0;
    unique case (addr_use)
      accel_out_pkg::ADDR_TEMP: read_byte = temp_q;
      accel_out_pkg::ADDR_MAG_LOW:
      begin
        read_byte = byte_order_select ? mag_q[11:4] : mag_q[7:0];
        clears_ready = 1'b1;
      end
      accel_out_pkg::ADDR_MAG_HIGH:
      begin
        read_byte = byte_order_select ? {mag_q[3:0], 4'h0} : {4'h0, mag_q[11:8]};
        clears_ready = 1'b1;
      end
      accel_out_pkg::ADDR_X_LOW, accel_out_pkg::ADDR_X_HIGH:
      begin
        read_byte = axis_byte(x_q, addr_use[0], byte_order_select, fast_read_select);
        clears_ready = 1'b1;
      end
      accel_out_pkg::ADDR_Y_LOW, accel_out_pkg::ADDR_Y_HIGH:
      begin
        read_byte = axis_byte(y_q, addr_use[0], byte_order_select, fast_read_select);
        clears_ready = 1'b1;
      end
      accel_out_pkg::ADDR_Z_LOW, accel_out_pkg::ADDR_Z_HIGH:
      begin
        read_byte = axis_byte(z_q, addr_use[0], byte_order_select, fast_read_select);
        clears_ready = 1'b1;
      end
      default: read_byte = 8'h00;
    endcase
    if (fast_read_select && addr_use >= accel_out_pkg::ADDR_X_LOW
        && addr_use <= accel_out_pkg::ADDR_Z_HIGH)
    begin
      addr_next = addr_use + 8'h02;
    end
    else
    begin
      addr_next = addr_use + 8'h01;
    end
  end

  // Host port: one answer per access, refused before boot
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ptr_q <= 8'h00;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      ack_q <= access && boot_done_q;
      refused_q <= access && !boot_done_q;
      if (access && boot_done_q)
      begin
        ptr_q <= addr_next;
        rdata_q <= reg_rd ? read_byte : 8'h00;
      end
    end
  end

  // Sample ready: new sample wins over a clearing read
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ready_q <= 1'b0;
    end
    else if (latch_now)
    begin
      ready_q <= 1'b1;
    end
    else if (reg_rd && boot_done_q && clears_ready)
    begin
      ready_q <= 1'b0;
    end
  end

  // Boot pulse generator
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pulse_q <= accel_out_pkg::PULSE_IDLE;
      pulse_cnt_q <= 14'h0000;
      pulse_second_q <= 1'b0;
      pulse_pol_q <= accel_out_pkg::POLARITY_RESET;
      pulse_od_q <= accel_out_pkg::DRIVER_RESET;
    end
    else
    begin
      unique case (pulse_q)
        accel_out_pkg::PULSE_IDLE:
        begin
          if (boot_finish && !boot_done_q && strap_s2_q)
          begin
            pulse_q <= accel_out_pkg::PULSE_ACTIVE;
            pulse_cnt_q <= 14'(BOOT_LONG_CYCLES - 1);
            pulse_second_q <= 1'b1;
            pulse_pol_q <= 1'b0;
            pulse_od_q <= 1'b1;
          end
          else if (boot_finish && !boot_done_q && boot_irq_enable)
          begin
            pulse_q <= accel_out_pkg::PULSE_ACTIVE;
            pulse_cnt_q <= 14'(accel_out_pkg::BOOT_SHORT_CYCLES - 1);
            pulse_second_q <= route_q;
            pulse_pol_q <= pol_q;
            pulse_od_q <= drv_q;
          end
        end
        accel_out_pkg::PULSE_ACTIVE:
        begin
          if (pulse_cnt_q == 14'h0000)
          begin
            pulse_q <= accel_out_pkg::PULSE_IDLE;
          end
          else
          begin
            pulse_cnt_q <= pulse_cnt_q - 14'h0001;
          end
        end
      endcase
    end
  end

  // Pin levels; open-drain pins only pull low
  always_comb
  begin
    drive1 = pin_drive(pulse_q == accel_out_pkg::PULSE_ACTIVE && !pulse_second_q,
                       pol_q, drv_q);
    drive2 = pin_drive(pulse_q == accel_out_pkg::PULSE_ACTIVE && pulse_second_q,
                       pol_q, drv_q);
    if (pulse_q == accel_out_pkg::PULSE_ACTIVE)
    begin
      drive1 = pin_drive(!pulse_second_q, pulse_pol_q, pulse_od_q);
      drive2 = pin_drive(pulse_second_q, pulse_pol_q, pulse_od_q);
      if (pulse_second_q)
      begin
        drive1 = pin_drive(1'b0, pol_q, drv_q);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin1_q <= 2'h0;
      pin2_q <= 2'h0;
    end
    else
    begin
      pin1_q <= drive1;
      pin2_q <= drive2;
    end
  end

  assign adc_start = start_q;
  assign adc_channel = chan_q;
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_refused = refused_q;
  assign boot_done_flag = boot_done_q;
  assign sample_ready_flag = ready_q;
  assign irq_polarity = pol_q;
  assign irq_driver_type = drv_q;
  assign boot_route_second = route_q;
  assign first_irq_pin_o = pin1_q[1];
  assign first_irq_pin_oe = pin1_q[0];
  assign second_irq_pin_o = pin2_q[1];
  assign second_irq_pin_oe = pin2_q[0];

endmodule

//--- test/accel_adc_model.sv
`timescale 1ns/10ps
module accel_adc_model (
  input wire logic core_clk,
  input wire logic adc_start,
  input wire logic [1:0] adc_channel,
  input wire logic [47:0] samples,
  input wire logic slow,
  output logic adc_done,
  output logic [11:0] adc_result
);
  logic [1:0] ch;
  initial
  begin
    adc_done = 1'b0;
    adc_result = 12'h000;
  end
  // Slow answers outlast the conversion spacing
  always
  begin
    @(posedge core_clk);
    #1;
    // A new start may come in the cycle in which the last answer drops
    while (adc_start === 1'b1)
    begin
      ch = adc_channel;
      repeat (slow ? 450 : 3) @(posedge core_clk);
      #1;
      adc_result = samples[ch * 12 +: 12];
      adc_done = 1'b1;
      @(posedge core_clk);
      #1;
      adc_done = 1'b0;
      adc_result = ~adc_result;
    end
  end
endmodule

//--- test/accel_out_checker_assertions.sv
`timescale 1ns/10ps
module accel_out_checker #(
  parameter int BOOT_LONG_CYCLES = accel_out_pkg::BOOT_LONG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic boot_strap_select,
  input wire logic boot_finish,
  input wire logic soft_reset,
  input wire logic hibernate_exit,
  input wire logic boot_irq_enable,
  input wire logic setup_write,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_first,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_refused,
  input wire logic boot_done_flag,
  input wire logic sample_ready_flag,
  input wire logic irq_polarity,
  input wire logic irq_driver_type,
  input wire logic boot_route_second,
  input wire logic adc_start,
  input wire logic [1:0] adc_channel,
  input wire logic first_irq_pin_o,
  input wire logic first_irq_pin_oe,
  input wire logic second_irq_pin_o,
  input wire logic second_irq_pin_oe
);
  logic [9:0] gap_q;
  logic [1:0] last_ch_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Cycles since the last conversion start
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gap_q <= 10'h000;
      last_ch_q <= 2'h0;
    end
    else if (adc_start)
    begin
      gap_q <= 10'h000;
      last_ch_q <= adc_channel;
    end
    else if (gap_q < 10'h3E8)
      gap_q <= gap_q + 10'h001;
  end
  access_refused_a: assert property ((reg_rd || reg_wr) && !boot_done_flag
    |=> reg_refused && !reg_ack) else $error("access answered before boot");
  access_acked_a: assert property (reg_rd && boot_done_flag
    |=> reg_ack && !reg_refused) else $error("read not acknowledged");
  write_ignored_a: assert property (reg_wr && boot_done_flag
    |=> reg_ack && reg_rdata == 8'h00) else $error("write not ignored");
  polarity_locked_a: assert property (setup_write && !boot_done_flag && !hibernate_exit
    |=> $stable(irq_polarity)) else $error("polarity written before boot");
  setup_kept_a: assert property (soft_reset && !setup_write && !hibernate_exit
    |=> $stable({irq_polarity, irq_driver_type, boot_route_second}))
    else $error("soft reset changed pin setup");
  ready_cleared_a: assert property (reg_rd && reg_first && boot_done_flag
    && reg_addr >= accel_out_pkg::ADDR_MAG_LOW && reg_addr <= accel_out_pkg::ADDR_Z_HIGH
    |-> ##[1:2] !sample_ready_flag) else $error("sample ready not cleared");
  conv_spacing_a: assert property (adc_start && adc_channel != accel_out_pkg::CHAN_TEMP
    |-> gap_q >= 10'(accel_out_pkg::CONV_GAP_CYCLES - 2)) else $error("conversions too close");
  conv_order_a: assert property (adc_start && adc_channel != accel_out_pkg::CHAN_TEMP
    |-> adc_channel == last_ch_q + 2'h1) else $error("conversion order wrong");
  short_pulse_a: assert property (boot_finish && !boot_done_flag && !boot_strap_select
    && boot_irq_enable && irq_polarity && !irq_driver_type && !boot_route_second
    |-> ##2 (first_irq_pin_o && first_irq_pin_oe)[*8]) else $error("short boot pulse wrong");
  long_pulse_a: assert property (boot_finish && !boot_done_flag && boot_strap_select
    |-> ##2 (second_irq_pin_oe && !second_irq_pin_o)[*8]) else $error("long boot pulse wrong");
  cover property (reg_refused);
  cover property (first_irq_pin_o && first_irq_pin_oe);
  cover property (sample_ready_flag && reg_ack);
endmodule
bind accel_output_data_registers accel_out_checker #(
  .BOOT_LONG_CYCLES(BOOT_LONG_CYCLES)
) i_accel_out_checker (.*);

//--- test/accel_output_data_registers_tb_top.sv
`timescale 1ns/10ps
module accel_output_data_registers_tb_top;
  localparam int LONG = 20;
  logic core_clk, rst_n, boot_strap_select, boot_finish, soft_reset, hibernate_exit;
  logic boot_irq_enable, setup_write, setup_polarity, setup_driver, setup_route;
  logic byte_order_select, fast_read_select, magnitude_enable, odr_tick, adc_start;
  logic adc_done, reg_rd, reg_wr, reg_first, reg_ack, reg_refused, boot_done_flag;
  logic sample_ready_flag, irq_polarity, irq_driver_type, boot_route_second, slow;
  logic first_irq_pin_o, first_irq_pin_oe, second_irq_pin_o, second_irq_pin_oe, booted;
  logic [1:0] adc_channel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a;
  logic [11:0] adc_result, t, x, y, z, mag;
  logic [47:0] samples;
  int seed = 19;
  int fails, checked, n;
  accel_output_data_registers #(.BOOT_LONG_CYCLES(LONG)) i_accel_output_data_registers (.*);
  accel_adc_model i_accel_adc_model (.*);
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  // Strobes stay up between calls; idle drops them
  task automatic acc(input logic wr, input logic first, input logic [7:0] ad);
    reg_rd <= !wr;
    reg_wr <= wr;
    reg_first <= first;
    reg_addr <= ad;
    reg_wdata <= 8'($random(seed));
    cyc(1);
    check("answer", {reg_ack, reg_refused}, booted ? 2'h2 : 2'h1);
    d = reg_rdata;
  endtask
  task automatic idle();
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic boot();
    pulse(boot_finish);
    booted = 1'b1;
    cyc(1);
  endtask
  function automatic logic [7:0] exp_b(input logic [7:0] ad);
    logic [11:0] v;
    logic big;
    big = byte_order_select;
    v = ad < 8'h06 ? x : ad < 8'h08 ? y : z;
    case (ad)
      8'h01: return t[7:0];
      8'h02: return big ? mag[11:4] : mag[7:0];
      8'h03: return big ? {mag[3:0], 4'h0} : {4'h0, mag[11:8]};
      8'h04, 8'h06, 8'h08: return (big || fast_read_select) ? v[11:4] : v[7:0];
      8'h05, 8'h07, 8'h09: return big ? {v[3:0], 4'h0} : {{4{v[11]}}, v[11:8]};
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [11:0] root(input int s);
    int r;
    r = 0;
    while ((r + 1) * (r + 1) <= s)
      r++;
    return 12'(r);
  endfunction
  initial
  begin
    {rst_n, boot_finish, soft_reset, hibernate_exit, setup_write, odr_tick} = '0;
    {reg_rd, reg_wr, reg_first, byte_order_select, fast_read_select, slow} = '0;
    {boot_strap_select, setup_polarity, setup_driver, setup_route, booted} = '0;
    {boot_irq_enable, magnitude_enable} = 2'h3;
    {reg_addr, reg_wdata, samples} = '0;
    {t, x, y, z, mag} = '0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    acc(1'b0, 1'b1, 8'h01);
    idle();
    pulse(setup_write);
    check("pol_early", irq_polarity, 1'b1);
    boot();
    cyc(1);
    check("boot_high", {first_irq_pin_o, first_irq_pin_oe, second_irq_pin_o}, 3'h6);
    cyc(120);
    check("boot_end", first_irq_pin_o, 1'b0);
    check("booted", boot_done_flag, 1'b1);
    for (int i = 1; i < 4; i++)
    begin
      acc(1'b0, 1'b1, 8'(i));
      check("reset_val", d, 8'h00);
    end
    idle();
    {setup_polarity, setup_driver, setup_route} = 3'h3;
    pulse(setup_write);
    pulse(soft_reset);
    booted = 1'b0;
    cyc(1);
    check("setup_kept", {irq_polarity, irq_driver_type, boot_route_second}, 3'h3);
    acc(1'b0, 1'b1, 8'h04);
    idle();
    boot();
    cyc(1);
    check("boot_low", {second_irq_pin_o, second_irq_pin_oe, first_irq_pin_oe}, 3'h2);
    cyc(120);
    pulse(hibernate_exit);
    booted = 1'b0;
    cyc(1);
    check("setup_dflt", {irq_polarity, irq_driver_type, boot_route_second}, 3'h4);
    boot_strap_select = 1'b1;
    cyc(4);
    boot();
    cyc(1);
    check("boot_long", {second_irq_pin_o, second_irq_pin_oe}, 2'h1);
    cyc(LONG - 4);
    check("boot_long", {second_irq_pin_o, second_irq_pin_oe}, 2'h1);
    cyc(10);
    for (int i = 0; i < 6; i++)
    begin
      samples = {16'($random(seed)), 32'($random(seed))};
      if (i == 0)
        samples[35:12] = 24'h7FF800;
      {z, y, x, t} = samples;
      {byte_order_select, fast_read_select, slow} = 3'($random(seed));
      if (i > 0)
        magnitude_enable = 1'($random(seed));
      pulse(odr_tick);
      cyc(20);
      pulse(odr_tick);
      n = 0;
      while (sample_ready_flag !== 1'b1 && n < 4000)
      begin
        cyc(1);
        n++;
      end
      check("ready", sample_ready_flag, 1'b1);
      if (magnitude_enable)
        mag = root(int'($signed(x)) ** 2 + int'($signed(y)) ** 2 + int'($signed(z)) ** 2);
      a = i[0] ? 8'h04 : 8'h01;
      acc(1'b0, 1'b1, a);
      check("burst", d, exp_b(a));
      check("first_clr", sample_ready_flag, a == 8'h01);
      repeat (8)
      begin
        a = (fast_read_select && a > 8'h03 && a < 8'h0A) ? a + 8'h02 : a + 8'h01;
        acc(1'b0, 1'b0, a);
        if (a == 8'h02)
          check("mag_clr", sample_ready_flag, 1'b0);
        check("burst", d, exp_b(a));
      end
      acc(1'b1, 1'b1, 8'h04);
      check("wr_data", d, 8'h00);
      acc(1'b0, 1'b1, 8'h04);
      check("after_wr", d, exp_b(8'h04));
      idle();
      check("ready_clr", sample_ready_flag, 1'b0);
    end
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule
